// ==== hw/sideband_init_pkg.sv ====
package sideband_init_pkg;
  localparam int unsigned CLK_MHZ = 125;
  // Reset must be held this many user clock cycles by the caller
  localparam int unsigned RESET_HOLD_CYCLES = 6;
  // Default timer durations in microseconds
  localparam int unsigned ALIGN_TIME_US = 20;
  localparam int unsigned BOND_TIME_US = 20;
  localparam int unsigned VERIFY_TIME_US = 40;
  localparam int unsigned WATCHDOG_TIME_US = 100;
  localparam int unsigned REINIT_TIME_US = 10000;
  localparam int unsigned ALIGN_CYCLES = ALIGN_TIME_US * CLK_MHZ;
  localparam int unsigned BOND_CYCLES = BOND_TIME_US * CLK_MHZ;
  localparam int unsigned VERIFY_CYCLES = VERIFY_TIME_US * CLK_MHZ;
  localparam int unsigned WATCHDOG_CYCLES = WATCHDOG_TIME_US * CLK_MHZ;
  localparam int unsigned REINIT_CYCLES = REINIT_TIME_US * CLK_MHZ;
  localparam int unsigned CNT_W = 24;
  // Sideband vector bit positions
  localparam int unsigned SB_ALIGNED = 0;
  localparam int unsigned SB_BONDED = 1;
  localparam int unsigned SB_VERIFY = 2;
  localparam int unsigned SB_RESET = 3;
  localparam int unsigned SB_W = 4;

  typedef enum logic [2:0] {
    ST_RESET   = 3'h0,
    ST_ALIGNED = 3'h1,
    ST_BONDED  = 3'h2,
    ST_VERIFY  = 3'h3,
    ST_READY   = 3'h4
  } init_state_type;
endpackage

// ==== hw/simplex_sideband_init.sv ====
// Summary of operation
// - Progress comes from sideband signals, or from timers on the transmit side in timer mode
// - Sideband set: aligned, bonded, verify, reset
// - Separate sets for transmit and receive
// - Bonded used only with multiple lanes
// - Transmit endpoint has no receive path
// - Three timers drive aligned, bonded, verify
// - Timer indications assert only on expiry
// - Receive watchdogs fall back to reset
// - Watchdog timeout is a parameter
// - Re-initialize after detected failure, and periodically in timer mode while enabled
// - Channel ready only after full initialization, except single-lane receive, which goes ready without checking lane verify
// - Receive ready precedes transmit ready when timer_mode_i is low
`timescale 1ns/1ps
module simplex_sideband_init
#(
  parameter int unsigned LANES = 2,
  parameter int unsigned ALIGN_CNT = sideband_init_pkg::ALIGN_CYCLES,
  parameter int unsigned BOND_CNT = sideband_init_pkg::BOND_CYCLES,
  parameter int unsigned VERIFY_CNT = sideband_init_pkg::VERIFY_CYCLES,
  parameter int unsigned WATCHDOG_CNT = sideband_init_pkg::WATCHDOG_CYCLES,
  parameter int unsigned REINIT_CNT = sideband_init_pkg::REINIT_CYCLES
) (
  input wire logic mclk_i, // User clock
  input wire logic srst_i, // Synchronous reset, high
  input wire logic timer_mode_i, // 1: transmit side driven by timers
  // Transmit endpoint
  input wire logic tx_aligned_i, // Back-channel aligned
  input wire logic tx_bonded_i, // Back-channel bonded
  input wire logic tx_verify_i, // Back-channel verify
  input wire logic tx_reset_i, // Back-channel reset
  input wire logic tx_fail_i, // Transmit hard failure
  output logic tx_channel_up_o, // Transmit channel ready
  output logic tx_send_init_o, // Transmit sends init sequence
  // Receive endpoint
  input wire logic rx_lane_aligned_i, // Receiver lanes aligned
  input wire logic rx_lane_bonded_i, // Receiver lanes bonded
  input wire logic rx_lane_verified_i, // Receiver verify seen
  input wire logic rx_fail_i, // Receive hard failure
  output logic rx_aligned_o, // Receive sideband aligned
  output logic rx_bonded_o, // Receive sideband bonded
  output logic rx_verify_o, // Receive sideband verify
  output logic rx_reset_o, // Receive sideband reset
  output logic rx_channel_up_o, // Receive channel ready
  output logic irq_o, // Interrupt level
  // Register port
  input wire logic [3:0] reg_addr_i, // Word address
  input wire logic [31:0] reg_wdata_i, // Write data
  input wire logic reg_wr_i, // Write strobe
  input wire logic reg_rd_i, // Read strobe
  output logic [31:0] reg_rdata_o // Read data, next cycle
);
  import sideband_init_pkg::*;

  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_EVENT = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  localparam logic [3:0] ADDR_CTRL = 4'h3;
  localparam int unsigned EV_W = 4;
  localparam logic [EV_W-1:0] EV_RESET = 4'h0;
  localparam logic [CNT_W-1:0] ALIGN_T = CNT_W'(ALIGN_CNT - 1);
  localparam logic [CNT_W-1:0] BOND_T = CNT_W'(BOND_CNT - 1);
  localparam logic [CNT_W-1:0] VERIFY_T = CNT_W'(VERIFY_CNT - 1);
  localparam logic [CNT_W-1:0] WDOG_T = CNT_W'(WATCHDOG_CNT - 1);
  localparam logic [CNT_W-1:0] REINIT_T = CNT_W'(REINIT_CNT - 1);
  localparam bit MULTI = (LANES > 1);

  typedef struct packed {
    logic [SB_W-1:0] txsb_m;
    logic [SB_W-1:0] txsb_s;
    logic [2:0] rxin_m;
    logic [2:0] rxin_s;
    logic [1:0] fail_m;
    logic [1:0] fail_s;
    init_state_type tx_st;
    init_state_type rx_st;
    logic [CNT_W-1:0] tx_cnt;
    logic [CNT_W-1:0] rx_cnt;
    logic [CNT_W-1:0] reinit_cnt;
    logic rx_up_seen;
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] mask;
    logic reinit_en;
    logic [31:0] rdata;
  } state_type;

  state_type s_reg, s_next;

  logic [SB_W-1:0] tx_sb;
  logic tx_up;
  logic rx_up;
  logic [EV_W-1:0] ev_set;
  logic tx_wd_expire;
  logic rx_wd_expire;
  logic reinit_fire;

  always_comb begin
    s_next = s_reg;
    ev_set = '0;
    tx_sb = '0;
    tx_wd_expire = 1'b0;
    rx_wd_expire = 1'b0;
    reinit_fire = 1'b0;
    tx_up = (s_reg.tx_st == ST_READY);
    rx_up = (s_reg.rx_st == ST_READY);

    // Inputs from other domains pass two flip-flops
    // two-stage synchronizers
    s_next.txsb_m = {tx_reset_i, tx_verify_i, tx_bonded_i, tx_aligned_i};
    s_next.txsb_s = s_reg.txsb_m;
    s_next.rxin_m = {rx_lane_verified_i, rx_lane_bonded_i, rx_lane_aligned_i};
    s_next.rxin_s = s_reg.rxin_m;
    s_next.fail_m = {rx_fail_i, tx_fail_i};
    s_next.fail_s = s_reg.fail_m;

    tx_sb = s_reg.txsb_s;
    if (!MULTI) begin
      tx_sb[SB_BONDED] = tx_sb[SB_ALIGNED];
    end

    // Transmit side sequencer
    s_next.tx_cnt = s_reg.tx_cnt + CNT_W'(1);
    if (timer_mode_i) begin
      unique case (s_reg.tx_st)
        ST_RESET: begin
          s_next.tx_st = ST_ALIGNED;
          s_next.tx_cnt = '0;
        end
        ST_ALIGNED: if (s_reg.tx_cnt >= ALIGN_T) begin
          s_next.tx_st = MULTI ? ST_BONDED : ST_VERIFY;
          s_next.tx_cnt = '0;
        end
        ST_BONDED: if (s_reg.tx_cnt >= BOND_T) begin
          s_next.tx_st = ST_VERIFY;
          s_next.tx_cnt = '0;
        end
        ST_VERIFY: if (s_reg.tx_cnt >= VERIFY_T) begin
          s_next.tx_st = ST_READY;
          s_next.tx_cnt = '0;
        end
        ST_READY: s_next.tx_cnt = '0;
        default: s_next.tx_st = ST_RESET;
      endcase
    end else begin
      unique case (s_reg.tx_st)
        ST_RESET: if (!tx_sb[SB_RESET] && tx_sb[SB_ALIGNED]) begin
          s_next.tx_st = ST_ALIGNED;
          s_next.tx_cnt = '0;
        end
        ST_ALIGNED: if (tx_sb[SB_BONDED]) begin
          s_next.tx_st = ST_BONDED;
          s_next.tx_cnt = '0;
        end
        ST_BONDED: if (tx_sb[SB_VERIFY]) begin
          s_next.tx_st = ST_VERIFY;
          s_next.tx_cnt = '0;
        end
        // transmit ready after receive
        // Back-channel verify alone could beat receive ready
        ST_VERIFY: if (s_reg.rx_up_seen && tx_sb[SB_VERIFY]) begin
          s_next.tx_st = ST_READY;
          s_next.tx_cnt = '0;
        end
        ST_READY: s_next.tx_cnt = '0;
        default: s_next.tx_st = ST_RESET;
      endcase
      if (s_reg.tx_st != ST_RESET && s_reg.tx_st != ST_READY && s_reg.tx_cnt >= WDOG_T) begin
        tx_wd_expire = 1'b1;
      end
      // Receive side fell back to reset
      if (tx_sb[SB_RESET] && s_reg.tx_st != ST_RESET) begin
        tx_wd_expire = 1'b1;
      end
    end

    s_next.reinit_cnt = s_reg.reinit_cnt + CNT_W'(1);
    // Period restarts whenever mode or enable drops
    if (!(timer_mode_i && s_reg.reinit_en) || s_reg.reinit_cnt >= REINIT_T) begin
      s_next.reinit_cnt = '0;
    end
    reinit_fire = timer_mode_i && s_reg.reinit_en && s_reg.reinit_cnt >= REINIT_T;

    if (s_reg.fail_s[0] || tx_wd_expire || reinit_fire) begin
      s_next.tx_st = ST_RESET;
      s_next.tx_cnt = '0;
    end

    // Receive side sequencer
    s_next.rx_cnt = s_reg.rx_cnt + CNT_W'(1);
    unique case (s_reg.rx_st)
      ST_RESET: if (s_reg.rxin_s[0]) begin
        s_next.rx_st = ST_ALIGNED;
        s_next.rx_cnt = '0;
      end
      ST_ALIGNED: if (!MULTI || s_reg.rxin_s[1]) begin
        s_next.rx_st = MULTI ? ST_BONDED : ST_VERIFY;
        s_next.rx_cnt = '0;
      end
      ST_BONDED: if (s_reg.rxin_s[2]) begin
        s_next.rx_st = ST_VERIFY;
        s_next.rx_cnt = '0;
      end
      ST_VERIFY: begin
        s_next.rx_st = ST_READY;
        s_next.rx_cnt = '0;
      end
      ST_READY: s_next.rx_cnt = '0;
      default: s_next.rx_st = ST_RESET;
    endcase
    if (s_reg.rx_st != ST_RESET && s_reg.rx_st != ST_READY && s_reg.rx_cnt >= WDOG_T) begin
      rx_wd_expire = 1'b1;
    end
    // failure or lost alignment drops receive
    if (s_reg.fail_s[1] || rx_wd_expire || (rx_up && !s_reg.rxin_s[0])) begin
      s_next.rx_st = ST_RESET;
      s_next.rx_cnt = '0;
    end

    // Remember receive ready for the transmit side
    if (rx_up) begin
      s_next.rx_up_seen = 1'b1;
    end
    if (s_next.rx_st == ST_RESET) begin
      s_next.rx_up_seen = 1'b0;
    end

    // Events: tx up, rx up, tx restart, rx watchdog
    ev_set[0] = (s_next.tx_st == ST_READY) && !tx_up;
    ev_set[1] = (s_next.rx_st == ST_READY) && !rx_up;
    ev_set[2] = tx_up && (s_next.tx_st == ST_RESET);
    ev_set[3] = rx_wd_expire;

    // Register access
    s_next.rdata = '0;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_STATUS: s_next.rdata = {24'h0, 1'b0, s_reg.rx_st, 1'b0, s_reg.tx_st};
        ADDR_EVENT: s_next.rdata = {28'h0, s_reg.events};
        ADDR_MASK: s_next.rdata = {28'h0, s_reg.mask};
        ADDR_CTRL: s_next.rdata = {31'h0, s_reg.reinit_en};
        default: s_next.rdata = '0;
      endcase
    end
    // Writes to read-only or unmapped words are dropped
    if (reg_wr_i && reg_addr_i == ADDR_MASK) begin
      s_next.mask = reg_wdata_i[EV_W-1:0];
    end
    if (reg_wr_i && reg_addr_i == ADDR_CTRL) begin
      s_next.reinit_en = reg_wdata_i[0];
    end
    // Read clears, new events win
    if (reg_rd_i && reg_addr_i == ADDR_EVENT) begin
      s_next.events = ev_set;
    end else begin
      s_next.events = s_reg.events | ev_set;
    end

    // Reset overrides every next-state value
    if (srst_i) begin
      s_next = '0;
      s_next.tx_st = ST_RESET;
      s_next.rx_st = ST_RESET;
      s_next.events = EV_RESET;
      s_next.reinit_en = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    s_reg <= s_next;
  end

  assign tx_send_init_o = !tx_up;
  assign tx_channel_up_o = tx_up;
  assign rx_channel_up_o = rx_up;
  assign rx_reset_o = (s_reg.rx_st == ST_RESET);
  assign rx_aligned_o = (s_reg.rx_st != ST_RESET);
  assign rx_bonded_o = MULTI && (s_reg.rx_st == ST_BONDED || s_reg.rx_st == ST_VERIFY || rx_up);
  assign rx_verify_o = (s_reg.rx_st == ST_VERIFY) || rx_up;
  assign irq_o = |(s_reg.events & s_reg.mask);
  assign reg_rdata_o = s_reg.rdata;
endmodule

// ==== verif/simplex_sideband_init_assertions.sv ====
`timescale 1ns/1ps
module simplex_sideband_init_assertions #(
  parameter int unsigned LANES = 2,
  parameter int unsigned ALIGN_CNT = 8,
  parameter int unsigned BOND_CNT = 8,
  parameter int unsigned VERIFY_CNT = 8,
  parameter int unsigned WATCHDOG_CNT = 64
) (
  input wire logic mclk_i, // User clock
  input wire logic srst_i, // Reset
  input wire logic timer_mode_i, // Timer mode
  input wire logic tx_channel_up_o, // Transmit ready
  input wire logic tx_send_init_o, // Transmit init
  input wire logic rx_lane_aligned_i, // Lane aligned
  input wire logic rx_fail_i, // Receive failure
  input wire logic rx_aligned_o, // Receive aligned
  input wire logic rx_bonded_o, // Receive bonded
  input wire logic rx_verify_o, // Receive verify
  input wire logic rx_reset_o, // Receive reset
  input wire logic rx_channel_up_o // Receive ready
);
  int run_cnt;
  int wd_cnt;
  // Cycles of timed init and of receive time outside reset and ready
  always_ff @(posedge mclk_i) begin
    run_cnt <= (srst_i || !tx_send_init_o || !timer_mode_i) ? 0 : run_cnt + 1;
    wd_cnt <= (srst_i || rx_reset_o || rx_channel_up_o) ? 0 : wd_cnt + 1;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  sequence good_link;
    (rx_lane_aligned_i && !rx_fail_i) [*5];
  endsequence
  chk_reset_state: assert property ($fell(srst_i) |-> rx_reset_o && !tx_channel_up_o && !rx_channel_up_o)
    else $error("state not cleared by reset");
  chk_send_init_inv: assert property (tx_send_init_o != tx_channel_up_o)
    else $error("init sending does not mirror ready");
  chk_rx_before_tx: assert property ($rose(tx_channel_up_o) && !timer_mode_i |-> rx_channel_up_o)
    else $error("transmit ready ahead of receive");
  chk_timer_min: assert property ($rose(tx_channel_up_o) && timer_mode_i
    |-> run_cnt >= ALIGN_CNT + (LANES > 1 ? BOND_CNT : 0) + VERIFY_CNT)
    else $error("timed ready before timers ran out");
  chk_watchdog_bound: assert property (wd_cnt <= 3 * WATCHDOG_CNT + 3)
    else $error("receive side stuck past watchdog");
  chk_link_holds: assert property (good_link ##0 rx_channel_up_o |=> rx_channel_up_o)
    else $error("receive ready dropped without failure");
  chk_sync_delay: assert property ($rose(rx_aligned_o) |-> $past(rx_lane_aligned_i, 3))
    else $error("aligned taken without synchronizer delay");
  chk_bonded_lanes: assert property (rx_bonded_o |-> LANES > 1)
    else $error("bonded shown on single lane");
  chk_sideband_order: assert property (rx_verify_o |-> rx_aligned_o && !rx_reset_o && (rx_bonded_o || LANES == 1))
    else $error("verify shown without earlier sideband steps");
endmodule
bind simplex_sideband_init simplex_sideband_init_assertions #(.LANES(LANES), .ALIGN_CNT(ALIGN_CNT),
  .BOND_CNT(BOND_CNT), .VERIFY_CNT(VERIFY_CNT), .WATCHDOG_CNT(WATCHDOG_CNT)) simplex_sideband_init_assertions_inst (
  .mclk_i, .srst_i, .timer_mode_i, .tx_channel_up_o, .tx_send_init_o, .rx_lane_aligned_i, .rx_fail_i,
  .rx_aligned_o, .rx_bonded_o, .rx_verify_o, .rx_reset_o, .rx_channel_up_o);

// ==== verif/sideband_partner.sv ====
`timescale 1ns/1ps
module sideband_partner #(
  parameter int LAG = 4
) (
  input wire logic clk_i, // User clock
  input wire logic srst_i, // Reset
  input wire logic send_init_i, // Far transmitter sends init
  input wire logic stall_i, // Withhold verify detection
  input wire logic [3:0] rx_sb_i, // Receive sideband reset, verify, bonded, aligned
  output logic [2:0] lane_o, // Lane verified, bonded, aligned
  output logic [3:0] bc_o // Back channel to transmit sideband
);
  int cnt;
  always_ff @(posedge clk_i) begin
    if (srst_i)
      cnt <= 0;
    else if (send_init_i && cnt < 99)
      cnt <= cnt + 1;
    bc_o <= rx_sb_i;
  end
  // Lane detection follows received init time; stall_i also withholds verify
  assign lane_o = {cnt > LAG + 4 && !stall_i, cnt > LAG + 2, cnt > LAG};
endmodule

// ==== verif/simplex_sideband_init_bench.sv ====
`timescale 1ns/1ps
module simplex_sideband_init_bench;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic timer_mode_i = 1'b0;
  logic tx_fail_i = 1'b0;
  logic rx_fail_i = 1'b0;
  logic stall = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [3:0] bc;
  logic [2:0] lane;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o;
  logic [31:0] rd_val;
  logic tx_channel_up_o, tx_send_init_o, rx_aligned_o, rx_bonded_o, rx_verify_o, rx_reset_o, rx_channel_up_o, irq_o;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  always #4 mclk_i = ~mclk_i;
  simplex_sideband_init #(.ALIGN_CNT(8), .BOND_CNT(8), .VERIFY_CNT(8), .WATCHDOG_CNT(64), .REINIT_CNT(200))
    simplex_sideband_init_inst (.mclk_i, .srst_i, .timer_mode_i, .tx_aligned_i(bc[0]), .tx_bonded_i(bc[1]),
    .tx_verify_i(bc[2]), .tx_reset_i(bc[3]), .tx_fail_i, .tx_channel_up_o, .tx_send_init_o,
    .rx_lane_aligned_i(lane[0]), .rx_lane_bonded_i(lane[1]), .rx_lane_verified_i(lane[2]), .rx_fail_i,
    .rx_aligned_o, .rx_bonded_o, .rx_verify_o, .rx_reset_o, .rx_channel_up_o, .irq_o, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
  sideband_partner sideband_partner_inst (.clk_i(mclk_i), .srst_i, .send_init_i(tx_send_init_o), .stall_i(stall),
    .rx_sb_i({rx_reset_o, rx_verify_o, rx_bonded_o, rx_aligned_o}), .lane_o(lane), .bc_o(bc));
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 rd_val = reg_rdata_o;
  endtask
  function automatic logic sig(input int k);
    return k == 0 ? rx_channel_up_o : k == 1 ? tx_channel_up_o : irq_o;
  endfunction
  task automatic await(input string nm, input int k, input logic v, input int lim);
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(posedge mclk_i);
      #1 n++;
    end
    check(nm, {31'h0, v}, {31'h0, sig(k)});
  endtask
  task automatic rst(input logic mode);
    @(posedge mclk_i);
    srst_i <= 1'b1;
    timer_mode_i <= mode;
    repeat (6) @(posedge mclk_i);
    srst_i <= 1'b0;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    rst(1'b0);
    rd(4'h0); check("status", 32'h0, rd_val); // idle at reset
    rd(4'h2); check("mask", 32'h0, rd_val);
    rd(4'h3); check("ctrl", 32'h1, rd_val);
    wr(4'hf, 32'h5); rd(4'hf); check("unmapped", 32'h0, rd_val);
    wr(4'h2, 32'h1);
    await("rx_up", 0, 1'b1, 300); // sideband bring-up
    await("tx_up", 1, 1'b1, 300); // back channel
    await("irq_on", 2, 1'b1, 4);
    rd(4'h0); check("status", 32'h44, rd_val); // both ready
    rd(4'h1); check("events", 32'h3, rd_val);
    await("irq_off", 2, 1'b0, 4);
    rd(4'h1); check("events_clr", 32'h0, rd_val);
    wr(4'h2, 32'h0);
    $display("test bring_up done");
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk_i);
      rx_fail_i <= (k == 0);
      tx_fail_i <= (k == 1);
      repeat (3) @(posedge mclk_i);
      rx_fail_i <= 1'b0;
      tx_fail_i <= 1'b0;
      await("fail_drop", k, 1'b0, 8); // failure restarts
      await("rx_back", 0, 1'b1, 300); // re-init
      await("tx_back", 1, 1'b1, 300); // re-init
    end
    rd(4'h1); check("events_fail", 32'h7, rd_val & 32'h7);
    $display("test failure done");
    stall <= 1'b1;
    rst(1'b0);
    repeat (300) @(posedge mclk_i);
    rd(4'h1); check("watchdog", 32'h8, rd_val & 32'h8); // stuck state
    stall <= 1'b0;
    await("rx_recover", 0, 1'b1, 400); // after fallback
    $display("test watchdog done");
    rst(1'b1);
    await("tx_timed", 1, 1'b1, 100); // timed ready
    check("timer_len", 32'h1, {31'h0, n >= 24 && n <= 30}); // summed timers
    check("rx_first", 32'h1, {31'h0, rx_channel_up_o}); // receive up first
    await("reinit_drop", 1, 1'b0, 260); // periodic restart
    await("reinit_up", 1, 1'b1, 60); // periodic restart
    wr(4'h3, 32'h0);
    await("tx_steady", 1, 1'b1, 60);
    repeat (400) @(posedge mclk_i);
    check("no_reinit", 32'h1, {31'h0, tx_channel_up_o}); // no spontaneous restart
    $display("test timer done");
    end_sim();
  end
endmodule
